/* rtl/remote_spi_master_regen.v */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "spi_regen_defs.vh"
module remote_spi_master_regen #(
  parameter UNIT_CYCLES = (`UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  input wire clkEnable,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // remote byte arrivals from the link
  input wire [7:0] linkByte,
  input wire linkByteToggle,
  input wire linkFrameActive,
  // local spi pins
  output reg spiClk,
  output reg spiMosi,
  output reg spiSelectN,
  input wire spiMiso,
  // readback to link and interrupt
  output reg [7:0] rxByte,
  output reg rxByteValid,
  output reg irq
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SEL = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_DONE = 3'h4;

  function [7:0] unitCount;
    input [3:0] field;
    begin
      unitCount = (({4'h0, field} + 8'h01) * UNIT_CYCLES[7:0]) - 8'h01;
    end
  endfunction

  function isMapped;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_EDGE_TIMING: isMapped = 1'b1;
        `ADDR_SELECT_TIMING: isMapped = 1'b1;
        `ADDR_CONFIG_STATUS: isMapped = 1'b1;
        `ADDR_IRQ_STATUS: isMapped = 1'b1;
        `ADDR_IRQ_ENABLE: isMapped = 1'b1;
        `ADDR_IRQ_CLEAR: isMapped = 1'b1;
        default: isMapped = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] edgeTiming;
  reg [3:0] selectTiming;
  reg overflowFlag;
  reg overflowClear;
  reg idleLevel;
  reg [1:0] irqStatus;
  reg [1:0] irqEnable;
  reg [2:0] state;
  reg [7:0] timer;
  reg [2:0] bitIndex;
  reg [7:0] shiftOut;
  reg [7:0] shiftIn;
  reg [7:0] pendByte;
  reg pendValid;
  reg [1:0] togSync;
  reg togSeen;
  reg [1:0] frameSync;
  reg [1:0] misoSync;
  reg [7:0] byteSync0;
  reg [7:0] byteSync1;
  wire busWrite = psel && penable && pwrite && pready;
  wire busSetup = psel && !penable;
  wire busRead = busSetup && !pwrite;
  wire arrival = togSync[1] ^ togSeen;
  wire takePend = (state == ST_IDLE || state == ST_DONE) && pendValid;
  wire overflowEvent = arrival && pendValid && !takePend;
  wire byteDone = state == ST_HOLD && timer == 8'h00 && bitIndex == 3'h0;
  wire frameDone = state == ST_DONE && !frameSync[1] && !pendValid;
  wire [1:0] irqEvents = {frameDone, overflowEvent};
  wire irqClearWrite = busWrite && paddr == `ADDR_IRQ_CLEAR;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      togSync <= 2'b00;
      togSeen <= 1'b0;
    end
    else if (clkEnable)
    begin
      togSync <= {togSync[0], linkByteToggle};
      togSeen <= togSync[1];
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      frameSync <= 2'b00;
    end
    else if (clkEnable)
    begin
      frameSync <= {frameSync[0], linkFrameActive};
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      misoSync <= 2'b00;
    end
    else if (clkEnable)
    begin
      misoSync <= {misoSync[0], spiMiso};
    end
  end

  // byte is stable long before its toggle is seen
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      byteSync0 <= 8'h00;
      byteSync1 <= 8'h00;
    end
    else if (clkEnable)
    begin
      byteSync0 <= linkByte;
      byteSync1 <= byteSync0;
    end
  end

  // error decided in setup so it stands together with ready
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clkEnable)
    begin
      pready <= busSetup;
      pslverr <= busSetup && pwrite && !isMapped(paddr);
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      edgeTiming <= `RST_EDGE_TIMING;
      selectTiming <= `RST_SELECT_TIMING;
      overflowClear <= 1'b0;
      idleLevel <= 1'b0;
      irqEnable <= 2'b00;
    end
    else if (clkEnable && busWrite)
    begin
      case (paddr)
        `ADDR_EDGE_TIMING: edgeTiming <= pwdata[7:0];
        `ADDR_SELECT_TIMING: selectTiming <= pwdata[3:0];
        `ADDR_CONFIG_STATUS:
        begin
          overflowClear <= pwdata[`BIT_OVERFLOW_CLEAR];
          idleLevel <= pwdata[`BIT_IDLE_LEVEL];
        end
        `ADDR_IRQ_ENABLE: irqEnable <= pwdata[1:0];
        default: irqEnable <= irqEnable;
      endcase
    end
  end

  // new events win over a clear in the same cycle
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irqStatus <= 2'b00;
      overflowFlag <= 1'b0;
      irq <= 1'b0;
    end
    else if (clkEnable)
    begin
      if (irqClearWrite)
        irqStatus <= (irqStatus & ~pwdata[1:0]) | irqEvents;
      else
        irqStatus <= irqStatus | irqEvents;
      if (overflowEvent)
        overflowFlag <= 1'b1;
      else if (overflowClear)
        overflowFlag <= 1'b0;
      irq <= |(irqStatus & irqEnable);
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
    end
    else if (clkEnable && busRead)
    begin
      case (paddr)
        `ADDR_EDGE_TIMING: prdata <= {24'h000000, edgeTiming};
        `ADDR_SELECT_TIMING: prdata <= {28'h0000000, selectTiming};
        `ADDR_CONFIG_STATUS: prdata <= {24'h000000, overflowFlag, 4'h0, overflowClear, 1'b0, idleLevel};
        `ADDR_IRQ_STATUS: prdata <= {30'h00000000, irqStatus};
        `ADDR_IRQ_ENABLE: prdata <= {30'h00000000, irqEnable};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      timer <= 8'h00;
      bitIndex <= 3'h0;
      shiftOut <= 8'h00;
      shiftIn <= 8'h00;
      pendByte <= 8'h00;
      pendValid <= 1'b0;
      spiClk <= 1'b0;
      spiMosi <= 1'b0;
      spiSelectN <= 1'b1;
      rxByte <= 8'h00;
      rxByteValid <= 1'b0;
    end
    else if (clkEnable)
    begin
      rxByteValid <= 1'b0;
      if (arrival && (!pendValid || takePend))
      begin
        pendByte <= byteSync1;
        pendValid <= 1'b1;
      end
      else if (takePend)
      begin
        pendValid <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          spiClk <= idleLevel;
          if (pendValid)
          begin
            spiSelectN <= 1'b0;
            shiftOut <= pendByte;
            timer <= unitCount(selectTiming);
            state <= ST_SEL;
          end
        end
        ST_SEL:
          if (timer != 8'h00)
          begin
            timer <= timer - 8'h01;
          end
          else
          begin
            spiMosi <= shiftOut[7];
            bitIndex <= 3'h7;
            timer <= unitCount(edgeTiming[3:0]);
            state <= ST_SETUP;
          end
        ST_SETUP:
          if (timer != 8'h00)
          begin
            timer <= timer - 8'h01;
          end
          else
          begin
            spiClk <= ~idleLevel;
            shiftIn <= {shiftIn[6:0], misoSync[1]};
            timer <= unitCount(edgeTiming[7:4]);
            state <= ST_HOLD;
          end
        ST_HOLD:
          if (timer != 8'h00)
          begin
            timer <= timer - 8'h01;
          end
          else
          begin
            spiClk <= idleLevel;
            if (bitIndex == 3'h0)
            begin
              rxByte <= shiftIn;
              rxByteValid <= 1'b1;
              state <= ST_DONE;
            end
            else
            begin
              spiMosi <= shiftOut[bitIndex - 3'h1];
              bitIndex <= bitIndex - 3'h1;
              timer <= unitCount(edgeTiming[3:0]);
              state <= ST_SETUP;
            end
          end
        ST_DONE:
          if (pendValid)
          begin
            shiftOut <= pendByte;
            spiMosi <= pendByte[7];
            bitIndex <= 3'h7;
            timer <= unitCount(edgeTiming[3:0]);
            state <= ST_SETUP;
          end
          else if (!frameSync[1])
          begin
            spiSelectN <= 1'b1;
            state <= ST_IDLE;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* rtl/spi_regen_defs.vh */
`ifndef SPI_REGEN_DEFS_VH
`define SPI_REGEN_DEFS_VH
`define ADDR_EDGE_TIMING 8'h60
`define ADDR_SELECT_TIMING 8'h61
`define ADDR_CONFIG_STATUS 8'h62
`define ADDR_IRQ_STATUS 8'h70
`define ADDR_IRQ_ENABLE 8'h71
`define ADDR_IRQ_CLEAR 8'h72
`define ADDR_FRAME_DATA 8'h73
`define RST_EDGE_TIMING 8'h22
`define RST_SELECT_TIMING 4'h2
`define RST_CONFIG 8'h00
`define UNIT_NS 40
`define CLK_PERIOD_NS 10
`define BIT_OVERFLOW 7
`define BIT_OVERFLOW_CLEAR 2
`define BIT_SAMPLE_PHASE 1
`define BIT_IDLE_LEVEL 0
`define IRQ_OVERFLOW 0
`define IRQ_FRAME_DONE 1
`endif

/* tb/remote_spi_master_regen_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_regen_checker(
  // clock, reset, apb
  input wire logic sys_clk, reset, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // spi pins and readback
  input wire logic spiClk, spiMosi, spiSelectN, rxByteValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic idleSeen = 1'b0;
  always @(posedge sys_clk)
    if (spiSelectN)
      idleSeen <= spiClk;
  answer_time_a: assert property (psel && !penable |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  phase_reads_zero_a: assert property (pready && !pwrite && paddr == 8'h62 |-> !prdata[1]) else $error("phase");
  clock_width_a: assert property ($changed(spiClk) |=> $stable(spiClk)[*3]) else $error("short clock");
  data_setup_a: assert property ($changed(spiMosi) && !spiSelectN |=> $stable(spiClk)[*3]) else $error("setup");
  data_hold_a: assert property ($changed(spiClk) && spiClk != idleSeen |=> $stable(spiMosi)[*3]) else $error("hold");
  select_setup_a: assert property ($fell(spiSelectN) |-> $stable(spiClk)[*4]) else $error("select");
  rx_pulse_a: assert property (rxByteValid |=> !rxByteValid) else $error("valid held");
endmodule
bind remote_spi_master_regen spi_regen_checker u_chk(.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .spiClk(spiClk),
  .spiMosi(spiMosi), .spiSelectN(spiSelectN), .rxByteValid(rxByteValid));
`default_nettype wire

/* tb/remote_spi_master_regen_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_spi_master_regen_tb_top;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, linkByteToggle = 0, linkFrameActive = 0;
  logic cpol = 0, chk = 1, err;
  logic [7:0] paddr = 8'h00, linkByte = 8'h00, txByte = 8'h00, rxByte, gotByte;
  logic [31:0] pwdata = 32'h0, prdata, rd, wv;
  logic pready, pslverr, spiClk, spiMosi, spiSelectN, spiMiso, rxByteValid, irq;
  logic [7:0] expQ[$];
  logic [31:0] rv[4] = '{32'h22, 32'h02, 32'h00, 32'h00};
  integer bad_count = 0, comparisons = 0, seed = 32'hec9c, i, n;
  always #5 sys_clk = ~sys_clk;
  remote_spi_master_regen u_dut(.sys_clk(sys_clk), .reset(reset), .clkEnable(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linkByte(linkByte), .linkByteToggle(linkByteToggle), .linkFrameActive(linkFrameActive), .spiClk(spiClk),
    .spiMosi(spiMosi), .spiSelectN(spiSelectN), .spiMiso(spiMiso), .rxByte(rxByte), .rxByteValid(rxByteValid),
    .irq(irq));
  spi_slave_model u_slave(.spiClk(spiClk), .spiSelectN(spiSelectN), .spiMosi(spiMosi), .idleLevel(cpol),
    .txByte(txByte), .spiMiso(spiMiso), .gotByte(gotByte));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge sys_clk);
    if (n == 50)
    begin
      bad_count++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] b);
    linkByte <= b;
    expQ.push_back(b);
    @(posedge sys_clk);
    linkByteToggle <= ~linkByteToggle;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic wait_idle;
    for (n = 0; n < 9000 && !(spiSelectN === 1'b1 && expQ.size() == 0); n++)
      @(posedge sys_clk);
    if (n == 9000)
    begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  always @(posedge sys_clk)
    if (rxByteValid === 1'b1 && chk)
    begin
      check("miso byte", {24'h0, txByte}, {24'h0, rxByte});
      check("mosi byte", {24'h0, expQ.pop_front()}, {24'h0, gotByte});
    end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    for (i = 0; i < 4; i++)
    begin
      apb(0, 8'h60 + i[7:0], 32'h0);
      check("reset value", rv[i], rd);
    end
    apb(1, 8'h63, 32'h1);
    check("unmapped write error", 32'h1, {31'h0, err});
    for (i = 0; i < 2; i++)
    begin
      cpol <= i[0];
      txByte <= $random(seed);
      apb(1, 8'h62, i);
      apb(0, 8'h62, 32'h0);
      check("config", i, rd);
      wv = $random(seed) & 32'h33;
      apb(1, 8'h60, wv);
      apb(0, 8'h60, 32'h0);
      check("edge timing", wv, rd);
      apb(1, 8'h61, $random(seed) & 32'h3);
      linkFrameActive <= 1;
      send($random(seed));
      send($random(seed));
      linkFrameActive <= 0;
      wait_idle;
      check("idle level", {31'h0, cpol}, {31'h0, spiClk});
    end
    chk <= 0;
    apb(1, 8'h60, 32'hFF);
    apb(1, 8'h71, 32'h1);
    for (i = 0; i < 3; i++)
      send(8'hA5);
    expQ.delete();
    wait_idle;
    apb(0, 8'h62, 32'h0);
    check("overflow kept", 32'h81, rd);
    check("irq", 32'h1, {31'h0, irq});
    apb(1, 8'h71, 32'h0);
    @(posedge sys_clk);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1, 8'h62, 32'h5);
    apb(0, 8'h62, 32'h0);
    check("overflow cleared", 32'h05, rd);
    apb(1, 8'h62, 32'h0);
    apb(1, 8'h72, 32'h1);
    apb(1, 8'h71, 32'h1);
    @(posedge sys_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* tb/spi_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model(
  // spi pins
  input wire logic spiClk, spiSelectN, spiMosi, idleLevel,
  // byte answered, byte heard
  input wire logic [7:0] txByte,
  output logic spiMiso,
  output logic [7:0] gotByte
);
  logic [7:0] outReg = 8'h00;
  logic [2:0] cnt = 3'h0;
  logic stale = 1'b0;
  assign spiMiso = spiSelectN ? stale : outReg[7];
  always @(negedge spiSelectN)
  begin
    outReg = txByte;
    cnt = 3'h0;
  end
  always @(posedge spiSelectN) stale = ~outReg[7];
  always @(spiClk)
    if (!spiSelectN && spiClk !== idleLevel)
      gotByte = {gotByte[6:0], spiMosi};
    else if (!spiSelectN)
    begin
      cnt = cnt + 3'h1;
      outReg = (cnt == 3'h0) ? txByte : outReg << 1;
    end
endmodule
`default_nettype wire
